/* core/tdzm_defs.svh */
`ifndef TDZM_DEFS_SVH
`define TDZM_DEFS_SVH

// clock period of the block
`define TDZM_CLK_NS 20

// falling-edge blanking time in diode mode (least time, rounds up)
`define TDZM_BLANK_NS 200
`define TDZM_BLANK_CYC ((`TDZM_BLANK_NS + `TDZM_CLK_NS - 1) / `TDZM_CLK_NS)

// flag delay after command rise (least time, rounds up)
`define TDZM_FLAG_DLY_NS 60
`define TDZM_FLAG_DLY_CYC ((`TDZM_FLAG_DLY_NS + `TDZM_CLK_NS - 1) / `TDZM_CLK_NS)

// flag pulse width (least time, rounds up)
`define TDZM_FLAG_WD_NS 100
`define TDZM_FLAG_WD_CYC ((`TDZM_FLAG_WD_NS + `TDZM_CLK_NS - 1) / `TDZM_CLK_NS)

// reverse conduction minimum time per drive strength code
`define TDZM_REV_NS_0 40
`define TDZM_REV_NS_1 60
`define TDZM_REV_NS_2 80
`define TDZM_REV_NS_3 100
`define TDZM_REV_CYC_0 ((`TDZM_REV_NS_0 + `TDZM_CLK_NS - 1) / `TDZM_CLK_NS)
`define TDZM_REV_CYC_1 ((`TDZM_REV_NS_1 + `TDZM_CLK_NS - 1) / `TDZM_CLK_NS)
`define TDZM_REV_CYC_2 ((`TDZM_REV_NS_2 + `TDZM_CLK_NS - 1) / `TDZM_CLK_NS)
`define TDZM_REV_CYC_3 ((`TDZM_REV_NS_3 + `TDZM_CLK_NS - 1) / `TDZM_CLK_NS)

// output reset values
`define TDZM_GATE_RST 1'h0
`define TDZM_FAULT_N_RST 1'h0
`define TDZM_FLAG_RST 1'h0
`define TDZM_RAIL_RST 1'h0

`endif

/* core/tdzm_pkg.sv */
package tdzm_pkg;

   // diode-mode machine states
   typedef enum logic [1:0] {
      DS_IDLE    = 2'b00,
      DS_BLANK   = 2'b01,
      DS_WATCH   = 2'b10,
      DS_CONDUCT = 2'b11
   } tdzm_dstate_t;

   // start-up sequencer states
   typedef enum logic [1:0] {
      SU_WAIT  = 2'b00,
      SU_BUILD = 2'b01,
      SU_RUN   = 2'b10
   } tdzm_su_t;

endpackage

/* core/tdzm_sync.sv */
`timescale 1ns/1ns
`default_nettype none

module tdzm_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_reg;

   // two stages; only the second stage is read downstream
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         meta_reg <= '0;
         q <= '0;
      end else begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule

`default_nettype wire

/* core/tdzm_tmr.sv */
`timescale 1ns/1ns
`default_nettype none

module tdzm_tmr #(
   parameter int TW = 8
) (
   input wire logic clk,
   input wire logic nrst,
   tdzm_tmr_if.timer t
);
   logic [TW-1:0] cnt_reg;

   // a start reloads even while busy, so a new request restarts the interval
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt_reg <= '0;
      end else if (t.start) begin
         cnt_reg <= t.len;
      end else if (cnt_reg != '0) begin
         cnt_reg <= cnt_reg - TW'(1);
      end
   end

   // done is high for one cycle, len cycles after the start cycle
   assign t.busy = (cnt_reg != '0);
   assign t.done = (cnt_reg == TW'(1));
endmodule

`default_nettype wire

/* core/tdzm_tmr_if.sv */
`timescale 1ns/1ns
`default_nettype none

// start/length request and busy/done answer of one interval timer
interface tdzm_tmr_if #(parameter int TW = 8);
   logic start;
   logic [TW-1:0] len;
   logic busy;
   logic done;
   modport owner (output start, output len, input busy, input done);
   modport timer (input start, input len, output busy, output done);
endinterface

`default_nettype wire

/* core/tdzm_top.sv */
// Behaviour
// RQ1: in diode mode a command falling edge forces state 1, transistor off
// RQ2: state 1 waits out the blanking time, then goes to state 2
// RQ3: blanking is a fixed count, never waits for positive drain voltage
// RQ4: state 2 keeps transistor off, moves to state 3 on negative drain
// RQ5: entering over-temperature shutdown starts the machine in state 2
// RQ6: state 3 turns transistor on, returns to state 2 on forward current
// RQ7: state 3 to 2 switches off; state 1 to 2 stays off
// RQ8: without command activity only states 2 and 3 alternate
// RQ9: every new falling edge restarts blanking; repeats are not blocked
// RQ10: controller should switch a device already in shutdown first
// RQ11: on command rise, check drain has been below zero this cycle
// RQ12: confirmed soft switch gives one fixed-width pulse after fixed delay
// RQ13: reverse conduction shorter than minimum time gives no pulse
// RQ14: hard or partial hard switching keeps flag low that cycle
// RQ15: minimum reverse conduction time depends on drive strength setting
// RQ16: fault output low while supply builds at power-on
// RQ17: rails build above upper threshold, halt below lower threshold
// RQ18: both rails good releases fault high and enables switching
// RQ19: fault clears only when both temperatures are below trip points
// RQ20: diode machine idle in driver shutdown, resumes when it clears
// RQ21: blanking, flag delay and flag width are parameterised counters
`include "tdzm_defs.svh"
`timescale 1ns/1ns
`default_nettype none

module tdzm_top #(
   parameter int TW = 8,
   parameter int BLANK_CYC = `TDZM_BLANK_CYC,
   parameter int FLAG_DLY_CYC = `TDZM_FLAG_DLY_CYC,
   parameter int FLAG_WD_CYC = `TDZM_FLAG_WD_CYC
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic sw_cmd_in,
   input wire logic drain_neg_in,
   input wire logic drain_fwd_cur_in,
   input wire logic overtemp_shutdown_in,
   input wire logic drv_overtemp_in,
   input wire logic vdd_above_hi_in,
   input wire logic vdd_below_lo_in,
   input wire logic pos_rail_ok_in,
   input wire logic neg_rail_ok_in,
   input wire logic [1:0] drive_strength_in,
   output logic gate_on,
   output logic fault_n,
   output logic zero_voltage_flag_out,
   output logic rail_enable,
   output logic thermal_diode_mode,
   output logic [1:0] diode_state
);

   // reverse conduction minimum in cycles for a drive strength code
   function automatic logic [7:0] rev_min_cyc(input logic [1:0] s);
      logic [7:0] r;
      r = 8'(`TDZM_REV_CYC_0);
      case (s)
         2'h1: r = 8'(`TDZM_REV_CYC_1);
         2'h2: r = 8'(`TDZM_REV_CYC_2);
         2'h3: r = 8'(`TDZM_REV_CYC_3);
         default: r = 8'(`TDZM_REV_CYC_0);
      endcase
      return r;
   endfunction

   logic cmd_s;
   logic neg_s;
   logic fwd_s;
   logic got_s;
   logic dot_s;
   logic vhi_s;
   logic vlo_s;
   logic pok_s;
   logic nok_s;
   logic [1:0] str_s;
   logic cmd_d_reg;
   logic cmd_fall;
   logic cmd_rise;
   logic run;
   logic diode_en;
   logic zv_ok;
   logic [7:0] neg_cnt_reg;
   tdzm_pkg::tdzm_dstate_t dstate_reg;
   tdzm_pkg::tdzm_dstate_t dstate_next;
   tdzm_pkg::tdzm_su_t su_reg;
   tdzm_pkg::tdzm_su_t su_next;
   logic gate_next;
   logic fault_n_next;

   tdzm_tmr_if #(.TW(TW)) blank_t ();
   tdzm_tmr_if #(.TW(TW)) dly_t ();
   tdzm_tmr_if #(.TW(TW)) wid_t ();

   // every pin is asynchronous to clk
   tdzm_sync #(.W(11)) u_sync (
      .clk(clk),
      .nrst(nrst),
      .d({sw_cmd_in, drain_neg_in, drain_fwd_cur_in, overtemp_shutdown_in,
          drv_overtemp_in, vdd_above_hi_in, vdd_below_lo_in, pos_rail_ok_in,
          neg_rail_ok_in, drive_strength_in}),
      .q({cmd_s, neg_s, fwd_s, got_s, dot_s, vhi_s, vlo_s, pok_s, nok_s,
          str_s})
   );

   // command edge detection on the synchronised level
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cmd_d_reg <= 1'h0;
      end else begin
         cmd_d_reg <= cmd_s;
      end
   end

   assign cmd_fall = cmd_d_reg & ~cmd_s;
   assign cmd_rise = ~cmd_d_reg & cmd_s;
   assign run = (su_reg == tdzm_pkg::SU_RUN);
   // driver shutdown suspends the diode machine entirely
   assign diode_en = run & got_s & ~dot_s; // RQ20

   // start-up sequencer: lower threshold always wins over upper
   always_comb begin
      su_next = su_reg;
      case (su_reg)
         tdzm_pkg::SU_WAIT: begin
            if (vhi_s && !vlo_s) begin
               su_next = tdzm_pkg::SU_BUILD; // RQ17
            end
         end
         tdzm_pkg::SU_BUILD: begin
            if (vlo_s) begin
               su_next = tdzm_pkg::SU_WAIT; // RQ17
            end else if (pok_s && nok_s) begin
               su_next = tdzm_pkg::SU_RUN; // RQ18
            end
         end
         tdzm_pkg::SU_RUN: begin
            if (vlo_s) begin
               su_next = tdzm_pkg::SU_WAIT;
            end
         end
         default: su_next = tdzm_pkg::SU_WAIT;
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         su_reg <= tdzm_pkg::SU_WAIT;
      end else begin
         su_reg <= su_next;
      end
   end

   // rails only build outside the wait state
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rail_enable <= `TDZM_RAIL_RST;
      end else begin
         rail_enable <= (su_next != tdzm_pkg::SU_WAIT); // RQ17
      end
   end

   // blanking timer restarts on every falling edge
   assign blank_t.start = diode_en & cmd_fall; // RQ9 RQ21
   assign blank_t.len = TW'(BLANK_CYC);

   tdzm_tmr #(.TW(TW)) u_blank (
      .clk(clk),
      .nrst(nrst),
      .t(blank_t)
   );

   // diode machine; a falling edge beats every transition but the drop to idle when disabled
   always_comb begin
      dstate_next = dstate_reg;
      if (!diode_en) begin
         dstate_next = tdzm_pkg::DS_IDLE; // RQ20
      end else if (cmd_fall) begin
         dstate_next = tdzm_pkg::DS_BLANK; // RQ1 RQ9
      end else begin
         case (dstate_reg)
            tdzm_pkg::DS_IDLE: dstate_next = tdzm_pkg::DS_WATCH; // RQ5
            tdzm_pkg::DS_BLANK: begin
               // fixed count only, so a missing drain rise cannot hang it
               if (blank_t.done) begin
                  dstate_next = tdzm_pkg::DS_WATCH; // RQ2 RQ3
               end
            end
            tdzm_pkg::DS_WATCH: begin
               if (neg_s) begin
                  dstate_next = tdzm_pkg::DS_CONDUCT; // RQ4 RQ8
               end
            end
            tdzm_pkg::DS_CONDUCT: begin
               if (fwd_s) begin
                  dstate_next = tdzm_pkg::DS_WATCH; // RQ6 RQ8
               end
            end
            default: dstate_next = tdzm_pkg::DS_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         dstate_reg <= tdzm_pkg::DS_IDLE;
      end else begin
         dstate_reg <= dstate_next;
      end
   end

   // gate follows the command normally, the diode machine in shutdown
   always_comb begin
      gate_next = 1'h0;
      if (!run || dot_s) begin
         gate_next = 1'h0;
      end else if (got_s) begin
         gate_next = (dstate_next == tdzm_pkg::DS_CONDUCT); // RQ1 RQ6 RQ7
      end else begin
         gate_next = cmd_s; // RQ18
      end
   end

   // fault is low until ready and while either sensor is hot
   assign fault_n_next = (su_next == tdzm_pkg::SU_RUN) & ~got_s & ~dot_s;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         gate_on <= `TDZM_GATE_RST;
         fault_n <= `TDZM_FAULT_N_RST;
         thermal_diode_mode <= 1'h0;
         diode_state <= 2'h0;
      end else begin
         gate_on <= gate_next;
         fault_n <= fault_n_next; // RQ16 RQ18 RQ19
         thermal_diode_mode <= (dstate_next != tdzm_pkg::DS_IDLE);
         diode_state <= dstate_next;
      end
   end

   // length of the current reverse conduction, saturating
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         neg_cnt_reg <= 8'h00;
      end else if (!neg_s) begin
         neg_cnt_reg <= 8'h00;
      end else if (neg_cnt_reg != 8'hff) begin
         neg_cnt_reg <= neg_cnt_reg + 8'h01;
      end
   end

   // drain still below zero and long enough at the command rise
   assign zv_ok = neg_s & (neg_cnt_reg >= rev_min_cyc(str_s)); // RQ11 RQ13 RQ14 RQ15

   assign dly_t.start = cmd_rise & run & ~got_s & ~dot_s & zv_ok; // RQ12
   assign dly_t.len = TW'(FLAG_DLY_CYC);
   assign wid_t.start = dly_t.done;
   assign wid_t.len = TW'(FLAG_WD_CYC);

   tdzm_tmr #(.TW(TW)) u_dly (
      .clk(clk),
      .nrst(nrst),
      .t(dly_t)
   );

   tdzm_tmr #(.TW(TW)) u_wid (
      .clk(clk),
      .nrst(nrst),
      .t(wid_t)
   );

   // pulse rises after the delay and lasts exactly the width count
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         zero_voltage_flag_out <= `TDZM_FLAG_RST;
      end else if (dly_t.done) begin
         zero_voltage_flag_out <= 1'h1; // RQ12
      end else if (wid_t.done) begin
         zero_voltage_flag_out <= 1'h0; // RQ12
      end
   end

   // helper counters read only by the checks below
   logic [7:0] st1_cnt;
   logic [7:0] flag_cnt;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st1_cnt <= 8'h00;
      end else if (dstate_reg == tdzm_pkg::DS_BLANK && !blank_t.start) begin
         st1_cnt <= st1_cnt + 8'h01;
      end else begin
         st1_cnt <= 8'h00;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         flag_cnt <= 8'h00;
      end else if (zero_voltage_flag_out) begin
         flag_cnt <= flag_cnt + 8'h01;
      end else begin
         flag_cnt <= 8'h00;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   st1_entry_a: assert property (diode_en && cmd_fall // RQ1
      |=> dstate_reg == tdzm_pkg::DS_BLANK && !gate_on)
      else $error("falling edge did not force state 1 with gate off");

   blank_exit_a: assert property (dstate_reg == tdzm_pkg::DS_BLANK // RQ2
      && st1_cnt == 8'(BLANK_CYC - 1) && diode_en && !cmd_fall
      |=> dstate_reg == tdzm_pkg::DS_WATCH)
      else $error("blanking end did not move to state 2");

   blank_bound_a: assert property (dstate_reg == tdzm_pkg::DS_BLANK // RQ3
      |-> st1_cnt < 8'(BLANK_CYC))
      else $error("state 1 outlasted the blanking count");

   neg_conduct_a: assert property (diode_en && !cmd_fall // RQ4
      && dstate_reg == tdzm_pkg::DS_WATCH && neg_s
      |=> dstate_reg == tdzm_pkg::DS_CONDUCT && gate_on)
      else $error("negative drain did not turn transistor on");

   ot_start_a: assert property (diode_en && !$past(diode_en) // RQ5
      && !cmd_fall |=> dstate_reg == tdzm_pkg::DS_WATCH)
      else $error("shutdown entry did not start in state 2");

   fwd_off_a: assert property (diode_en && !cmd_fall // RQ7
      && dstate_reg == tdzm_pkg::DS_CONDUCT && fwd_s
      |=> dstate_reg == tdzm_pkg::DS_WATCH && !gate_on)
      else $error("forward current did not switch transistor off");

   drv_idle_a: assert property (dot_s // RQ20
      |=> dstate_reg == tdzm_pkg::DS_IDLE && !gate_on)
      else $error("diode machine active in driver shutdown");

   flag_width_a: assert property (!zero_voltage_flag_out // RQ12
      && $past(zero_voltage_flag_out) |-> $past(flag_cnt) == 8'(FLAG_WD_CYC - 1))
      else $error("flag pulse width wrong");

   fault_low_a: assert property (su_reg != tdzm_pkg::SU_RUN // RQ16
      |-> !fault_n)
      else $error("fault released before rails were ready");

   hot_fault_a: assert property (got_s || dot_s |=> !fault_n) // RQ19
      else $error("fault released while still hot");

   rail_halt_a: assert property (vlo_s |=> !rail_enable // RQ17
      && su_reg == tdzm_pkg::SU_WAIT)
      else $error("rails kept building below lower threshold");

   ready_run_a: assert property (su_reg == tdzm_pkg::SU_BUILD // RQ18
      && pok_s && nok_s && !vlo_s |=> su_reg == tdzm_pkg::SU_RUN)
      else $error("rails good did not release the device");

   st3_seen_c: cover property (dstate_reg == tdzm_pkg::DS_CONDUCT);
   blank_seen_c: cover property (dstate_reg == tdzm_pkg::DS_BLANK ##1
      dstate_reg == tdzm_pkg::DS_WATCH);
   flag_seen_c: cover property ($rose(zero_voltage_flag_out));
   run_seen_c: cover property ($rose(fault_n));

endmodule

`default_nettype wire

/* tb/tdzm_ctrl_model.sv */
`timescale 1ns/1ns
`default_nettype none

// converter controller: drives the switch command, optionally after a lead
// phase of negative drain, which stands in for reverse conduction
module tdzm_ctrl_model (
   input wire logic clk,
   input wire logic nrst,
   input wire logic req,
   input wire logic [7:0] lead_cyc,
   input wire logic [7:0] on_cyc,
   input wire logic neg_force,
   output logic sw_cmd,
   output logic drain_neg,
   output logic busy
);
   logic [1:0] ph_reg;
   logic [7:0] cnt_reg;
   logic neg_reg;

   // idle, lead, on, gap; the gap keeps consecutive pulses apart
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ph_reg <= 2'h0;
         cnt_reg <= 8'h00;
         sw_cmd <= 1'h0;
         neg_reg <= 1'h0;
      end else begin
         case (ph_reg)
            2'h0: if (req && lead_cyc != 8'h00) begin
               ph_reg <= 2'h1;
               cnt_reg <= lead_cyc;
               neg_reg <= 1'h1;
            end else if (req) begin
               ph_reg <= 2'h2;
               cnt_reg <= on_cyc;
               sw_cmd <= 1'h1;
            end
            2'h1: if (cnt_reg == 8'h01) begin
               ph_reg <= 2'h2;
               cnt_reg <= on_cyc;
               sw_cmd <= 1'h1;
            end else begin
               cnt_reg <= cnt_reg - 8'h01;
            end
            // negative drain still seen in the rise cycle, then dropped
            2'h2: begin
               neg_reg <= 1'h0;
               if (cnt_reg == 8'h01) begin
                  ph_reg <= 2'h3;
                  cnt_reg <= 8'h02;
                  sw_cmd <= 1'h0;
               end else begin
                  cnt_reg <= cnt_reg - 8'h01;
               end
            end
            default: if (cnt_reg == 8'h01) begin
               ph_reg <= 2'h0;
            end else begin
               cnt_reg <= cnt_reg - 8'h01;
            end
         endcase
      end
   end

   assign busy = (ph_reg != 2'h0);
   assign drain_neg = neg_reg | neg_force;
endmodule

`default_nettype wire

/* tb/tdzm_top_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none

module tdzm_top_tb_top;
   localparam int BC = 8;
   localparam int FD = 4;
   localparam int FW = 3;
   logic clk = 1'h0;
   logic nrst = 1'h0;
   logic req = 1'h0;
   logic [7:0] lead_r = 8'h00;
   logic [7:0] on_r = 8'h02;
   logic neg_f = 1'h0;
   logic fwd = 1'h0;
   logic overtemp_shutdown = 1'h0;
   logic drv = 1'h0;
   logic vhi = 1'h0;
   logic vlo = 1'h0;
   logic pok = 1'h0;
   logic nok = 1'h0;
   logic [1:0] ds = 2'h0;
   wire sw_cmd;
   wire drain_neg;
   wire busy;
   logic gate_on;
   logic fault_n;
   logic zero_voltage_flag_out;
   logic rail_enable;
   logic thermal_diode_mode;
   logic [1:0] diode_state;
   int bad_count = 0;
   int cmp_count = 0;
   int cyc_cnt = 0;
   int flag_hi = 0;
   int flag_rises = 0;
   int flag_cyc = 0;
   int cmd_cyc = 0;
   int gate_hi = 0;
   int st1_run = 0;
   int st1_gate = 0;
   int last_st1 = 0;
   logic prev_flag = 1'h0;
   logic prev_cmd = 1'h0;

   initial begin
      forever #10 clk = ~clk;
   end

   tdzm_ctrl_model ctrl (.clk(clk), .nrst(nrst), .req(req), .lead_cyc(lead_r),
      .on_cyc(on_r), .neg_force(neg_f), .sw_cmd(sw_cmd), .drain_neg(drain_neg), .busy(busy));

   tdzm_top #(.TW(8), .BLANK_CYC(BC), .FLAG_DLY_CYC(FD), .FLAG_WD_CYC(FW)) dut (
      .clk(clk), .nrst(nrst), .sw_cmd_in(sw_cmd), .drain_neg_in(drain_neg),
      .drain_fwd_cur_in(fwd), .overtemp_shutdown_in(overtemp_shutdown), .drv_overtemp_in(drv),
      .vdd_above_hi_in(vhi), .vdd_below_lo_in(vlo), .pos_rail_ok_in(pok),
      .neg_rail_ok_in(nok), .drive_strength_in(ds), .gate_on(gate_on),
      .fault_n(fault_n), .zero_voltage_flag_out(zero_voltage_flag_out),
      .rail_enable(rail_enable), .thermal_diode_mode(thermal_diode_mode),
      .diode_state(diode_state));

   task give_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // output history seen at each edge; one place so tasks only read it
   always @(posedge clk) begin
      cyc_cnt++;
      if (zero_voltage_flag_out === 1'h1) flag_hi++;
      if (zero_voltage_flag_out === 1'h1 && prev_flag !== 1'h1) begin
         flag_rises++;
         flag_cyc = cyc_cnt;
      end
      if (sw_cmd === 1'h1 && prev_cmd !== 1'h1) cmd_cyc = cyc_cnt;
      if (gate_on === 1'h1) gate_hi++;
      if (diode_state === 2'h1) begin
         st1_run++;
         if (gate_on === 1'h1) st1_gate++;
      end else if (st1_run != 0) begin
         last_st1 = st1_run;
         st1_run = 0;
      end
      prev_flag = zero_voltage_flag_out;
      prev_cmd = sw_cmd;
      if (cyc_cnt > 20000) begin
         bad_count++;
         give_verdict();
      end
   end

   task chk(input bit ok, input string msg);
      cmp_count++;
      if (!ok) begin
         bad_count++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask

   // let pin changes cross the sync stages and land before sampling
   task settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task pulse(input logic [7:0] lead, input logic [7:0] on);
      int i;
      @(posedge clk);
      lead_r <= lead;
      on_r <= on;
      req <= 1'h1;
      i = 0;
      @(posedge clk);
      // hold req until the model is seen busy at an edge
      while (busy !== 1'h1 && i < 4) begin
         i = i + 1;
         @(posedge clk);
      end
      if (busy !== 1'h1) begin
         bad_count++;
         $display("CHECK FAILED at %0t: controller ignored request", $time);
      end
      req <= 1'h0;
      i = 0;
      @(posedge clk);
      while (busy === 1'h1 && i < 300) begin
         i = i + 1;
         @(posedge clk);
      end
      // a stuck controller must not pass as a quiet return
      if (busy === 1'h1) begin
         bad_count++;
         $display("CHECK FAILED at %0t: controller stuck busy", $time);
      end
   endtask

   task t_startup();
      int g0;
      chk(fault_n === 1'h0 && gate_on === 1'h0 && rail_enable === 1'h0, "reset outs");
      @(posedge clk);
      vhi <= 1'h1;
      settle(6);
      chk(rail_enable === 1'h1 && fault_n === 1'h0, "rails not building");
      @(posedge clk);
      vlo <= 1'h1;
      vhi <= 1'h0;
      settle(6);
      chk(rail_enable === 1'h0, "rails not halted");
      @(posedge clk);
      vlo <= 1'h0;
      settle(6);
      chk(rail_enable === 1'h0, "rails resumed below upper");
      g0 = gate_hi;
      pulse(8'h00, 8'h05);
      settle(6);
      chk(gate_hi == g0, "gate switched before ready");
      @(posedge clk);
      vhi <= 1'h1;
      pok <= 1'h1;
      settle(6);
      chk(fault_n === 1'h0, "fault released on one rail");
      @(posedge clk);
      nok <= 1'h1;
      settle(6);
      chk(fault_n === 1'h1, "fault not released");
      g0 = gate_hi;
      pulse(8'h00, 8'h07);
      settle(6);
      chk(gate_hi - g0 == 7, "gate not following command");
   endtask

   task zvd_case(input logic [1:0] code, input logic [7:0] lead, input bit exp);
      int r0;
      int h0;
      @(posedge clk);
      ds <= code;
      settle(4);
      r0 = flag_rises;
      h0 = flag_hi;
      pulse(lead, 8'h0a);
      settle(12);
      if (exp) begin
         chk(flag_rises - r0 == 1 && flag_hi - h0 == FW, "flag pulse count or width");
         // two sync stages plus the flag output register after the delay count
         chk(flag_cyc - cmd_cyc == FD + 3, "flag delay");
      end else begin
         chk(flag_rises == r0, "flag without soft switch");
      end
   endtask

   task t_zvd();
      zvd_case(2'h0, 8'h03, 1'b1);
      zvd_case(2'h3, 8'h03, 1'b0);
      zvd_case(2'h3, 8'h07, 1'b1);
      zvd_case(2'h1, 8'h04, 1'b1);
      zvd_case(2'h2, 8'h02, 1'b0);
      zvd_case(2'h0, 8'h01, 1'b0);
      zvd_case(2'h0, 8'h00, 1'b0);
   endtask

   task t_diode();
      @(posedge clk);
      overtemp_shutdown <= 1'h1;
      settle(6);
      chk(thermal_diode_mode === 1'h1 && diode_state === 2'h2 && gate_on === 1'h0, "entry");
      chk(fault_n === 1'h0, "fault not raised when hot");
      @(posedge clk);
      neg_f <= 1'h1;
      settle(6);
      chk(diode_state === 2'h3 && gate_on === 1'h1, "no conduct on neg drain");
      @(posedge clk);
      neg_f <= 1'h0;
      fwd <= 1'h1;
      settle(6);
      chk(diode_state === 2'h2 && gate_on === 1'h0, "no turn off on fwd");
      @(posedge clk);
      fwd <= 1'h0;
      neg_f <= 1'h1;
      settle(6);
      chk(diode_state === 2'h3, "no return to conduct");
      // switch the hot device first so it passes the blanking state
      pulse(8'h00, 8'h03);
      settle(BC + 8);
      chk(last_st1 == BC && st1_gate == 0, "blanking length or gate");
      chk(diode_state === 2'h3 && gate_on === 1'h1, "no resume after blank");
      // second fall lands inside the first blanking and must restart it
      pulse(8'h00, 8'h03);
      pulse(8'h00, 8'h03);
      settle(BC + 8);
      chk(last_st1 > BC && last_st1 < BC + 14 && st1_gate == 0, "restart");
   endtask

   task t_drv_hot();
      @(posedge clk);
      drv <= 1'h1;
      settle(6);
      chk(thermal_diode_mode === 1'h0 && gate_on === 1'h0, "diode on in drv hot");
      @(posedge clk);
      drv <= 1'h0;
      settle(6);
      chk(thermal_diode_mode === 1'h1, "diode mode not resumed");
      @(posedge clk);
      drv <= 1'h1;
      overtemp_shutdown <= 1'h0;
      neg_f <= 1'h0;
      settle(6);
      chk(fault_n === 1'h0, "fault cleared while driver hot");
      @(posedge clk);
      drv <= 1'h0;
      settle(6);
      chk(fault_n === 1'h1 && thermal_diode_mode === 1'h0, "no recovery");
   endtask

   initial begin
      repeat (8) @(posedge clk);
      nrst <= 1'h1;
      settle(1);
      t_startup();
      t_zvd();
      t_diode();
      t_drv_hot();
      give_verdict();
   end
endmodule

`default_nettype wire
